// >>> include/standby_pkg.sv
// Shared constants and types of the standby mode control block
package standby_pkg;
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] MODE_OFF = 12'h004;
  localparam logic [11:0] SETTLE_OFF = 12'h008;
  localparam logic [11:0] STAT_OFF = 12'h00C;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int NMIA_MASK_BIT = 0;
  localparam int NMIB_MASK_BIT = 1;
  localparam int IRQ_MASK_BIT = 2;
  localparam int START_BIT = 3;
  localparam int SEL_W = 2;
  localparam int SETTLE_SEL_W = 3;
  localparam logic [7:0] SETTLE_RESET = 8'h06;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SEL_FIRST_IDLE = 2'h0;
  localparam logic [1:0] SEL_STOP = 2'h2;
  // Settle wait is 2^(base + select) oscillator periods; 10 + 6 gives 2^16
  localparam int SETTLE_BASE_LOG2 = 10;
  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_HALT = 6'h02,
    ST_IDLE = 6'h04,
    ST_STOP = 6'h08,
    ST_OSC_WAIT = 6'h10,
    ST_SETTLE = 6'h20
  } state_t;
endpackage : standby_pkg

// >>> include/settle_if.sv
// Link between the standby controller and its settle counter
interface settle_if;
  logic run;
  logic [2:0] sel;
  logic done;
  modport ctrl (output run, output sel, input done);
  modport counter (input run, input sel, output done);
endinterface : settle_if

// >>> design/settle_counter.sv
// Oscillation settle counter running on the main oscillator clock
module settle_counter #(
  parameter int BASE_LOG2 = standby_pkg::SETTLE_BASE_LOG2,
  parameter int CNT_W = BASE_LOG2 + 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  settle_if.counter sif
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } cnt_t;

  cnt_t s_r;
  cnt_t s_nxt;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << (BASE_LOG2 + int'(sif.sel))) - 1);

  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = sif.run ? CNT_W'(s_r.cnt + 1'b1) : '0;
    s_nxt.done = sif.run && (s_r.cnt == limit);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sif.done = s_r.done;

  count_reach_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_r.done |-> $past(sif.run) && $past(s_r.cnt) == $past(limit))
    else $error("settle done without full count");
endmodule : settle_counter

// >>> design/standby_mode_control.sv
// Standby mode controller with APB registers
// Contract
// - Mode select bits act only while the start bit is set
// - Settle counting begins only once the oscillator runs again
// - Settle register resets to 06H, giving 2^16 periods after reset
// - Halt with pending request enters halt, then leaves at once
// - First idle with pending unmasked request is released at once
// - Sources masked by standby mask bits do not release first idle
//
// The placing of the registers and the APB register port were left to the implementer.
module standby_mode_control #(
  parameter int BASE_LOG2 = standby_pkg::SETTLE_BASE_LOG2
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_req_in,
  input wire logic irq_pending_in,
  input wire logic nmi_a_in,
  input wire logic nmi_b_in,
  input wire logic osc_running_in,
  output logic cpu_clk_en_out,
  output logic osc_stop_out,
  output logic [5:0] state_out
);
  typedef struct packed {
    standby_pkg::state_t st;
    logic [2:0] masks;
    logic start;
    logic [1:0] sel;
    logic [7:0] settle;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_clk_en;
    logic osc_stop;
    logic run;
    logic wr_seen;
  } ctl_t;

  ctl_t s_r;
  ctl_t s_nxt;
  settle_if sif ();
  logic acc_first;
  logic wr_commit;
  logic wake_any;
  logic wake_masked;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  settle_counter #(
    .BASE_LOG2(BASE_LOG2),
    .CNT_W(BASE_LOG2 + 8)
  ) u_settle (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sif(sif)
  );

  // ----------------------------------------
  // Bus and wake decode
  // ----------------------------------------
  // One wait state keeps every bus output straight from a flop
  assign acc_first = psel && penable && !s_r.pready;
  assign wr_commit = psel && penable && s_r.pready && pwrite;
  // Halt ignores the standby masks
  assign wake_any = irq_pending_in || nmi_a_in || nmi_b_in;
  assign wake_masked = (nmi_a_in && !s_r.masks[standby_pkg::NMIA_MASK_BIT])
    || (nmi_b_in && !s_r.masks[standby_pkg::NMIB_MASK_BIT])
    || (irq_pending_in && !s_r.masks[standby_pkg::IRQ_MASK_BIT]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = acc_first;
    s_nxt.pslverr = 1'b0;
    if (acc_first) begin
      s_nxt.prdata = '0;
      if (hit(paddr, standby_pkg::CTRL_OFF)) begin
        s_nxt.prdata[standby_pkg::START_BIT:0] = {s_r.start, s_r.masks};
      end else if (hit(paddr, standby_pkg::MODE_OFF)) begin
        s_nxt.prdata[standby_pkg::SEL_W-1:0] = s_r.sel;
      end else if (hit(paddr, standby_pkg::SETTLE_OFF)) begin
        s_nxt.prdata[7:0] = s_r.settle;
      end else if (hit(paddr, standby_pkg::STAT_OFF)) begin
        s_nxt.prdata[5:0] = s_r.st;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (wr_commit) begin
      if (hit(paddr, standby_pkg::CTRL_OFF)) begin
        s_nxt.masks = pwdata[standby_pkg::IRQ_MASK_BIT:0];
        s_nxt.start = pwdata[standby_pkg::START_BIT];
      end else if (hit(paddr, standby_pkg::MODE_OFF)) begin
        s_nxt.sel = pwdata[standby_pkg::SEL_W-1:0];
      end else if (hit(paddr, standby_pkg::SETTLE_OFF)) begin
        // All eight bits are kept; upper bits are the program's to keep zero
        s_nxt.settle = pwdata[7:0];
        s_nxt.wr_seen = 1'b1;
      end
    end
    case (s_r.st)
      standby_pkg::ST_RUN: begin
        if (halt_req_in) begin
          s_nxt.st = standby_pkg::ST_HALT;
        end else if (s_r.start) begin
          s_nxt.start = 1'b0;
          if (s_r.sel == standby_pkg::SEL_FIRST_IDLE) begin
            s_nxt.st = standby_pkg::ST_IDLE;
          end else if (s_r.sel == standby_pkg::SEL_STOP) begin
            s_nxt.st = standby_pkg::ST_STOP;
          end
        end
      end
      standby_pkg::ST_HALT: begin
        if (wake_any) begin
          s_nxt.st = standby_pkg::ST_RUN;
        end
      end
      standby_pkg::ST_IDLE: begin
        if (wake_masked) begin
          s_nxt.st = standby_pkg::ST_RUN;
        end
      end
      standby_pkg::ST_STOP: begin
        if (wake_masked) begin
          s_nxt.st = standby_pkg::ST_OSC_WAIT;
        end
      end
      standby_pkg::ST_OSC_WAIT: begin
        if (osc_running_in) begin
          s_nxt.st = standby_pkg::ST_SETTLE;
        end
      end
      standby_pkg::ST_SETTLE: begin
        if (sif.done) begin
          s_nxt.st = standby_pkg::ST_RUN;
        end
      end
      default: begin
        s_nxt.st = standby_pkg::ST_OSC_WAIT;
      end
    endcase
    s_nxt.cpu_clk_en = (s_nxt.st == standby_pkg::ST_RUN);
    s_nxt.osc_stop = (s_nxt.st == standby_pkg::ST_STOP);
    s_nxt.run = (s_nxt.st == standby_pkg::ST_SETTLE) && !sif.done;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // settle reset value
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '{st: standby_pkg::ST_OSC_WAIT, masks: standby_pkg::MASK_RESET,
               start: 1'b0, sel: standby_pkg::SEL_RESET,
               settle: standby_pkg::SETTLE_RESET, prdata: '0, pready: 1'b0,
               pslverr: 1'b0, cpu_clk_en: 1'b0, osc_stop: 1'b0, run: 1'b0,
               wr_seen: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sif.run = s_r.run;
  assign sif.sel = s_r.settle[standby_pkg::SETTLE_SEL_W-1:0];
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign cpu_clk_en_out = s_r.cpu_clk_en;
  assign osc_stop_out = s_r.osc_stop;
  assign state_out = s_r.st;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  select_gate_a: assert property (
    s_r.st == standby_pkg::ST_RUN && !s_r.start && !halt_req_in
    |=> s_r.st == standby_pkg::ST_RUN)
    else $error("mode left without start bit");
  osc_hold_a: assert property (
    s_r.st == standby_pkg::ST_OSC_WAIT |-> !sif.run && !cpu_clk_en_out)
    else $error("settle count before oscillation");
  settle_reset_a: assert property (
    !s_r.wr_seen |-> s_r.settle == standby_pkg::SETTLE_RESET)
    else $error("settle register lost reset value");
  halt_exit_a: assert property (
    s_r.st == standby_pkg::ST_HALT && wake_any
    |=> s_r.st == standby_pkg::ST_RUN ##0 cpu_clk_en_out)
    else $error("halt not released by pending request");
  idle_release_a: assert property (
    s_r.st == standby_pkg::ST_IDLE && wake_masked |=> cpu_clk_en_out)
    else $error("first idle not released");
  idle_masked_a: assert property (
    s_r.st == standby_pkg::ST_IDLE && !wake_masked |=> s_r.st == standby_pkg::ST_IDLE)
    else $error("masked source released first idle");
  clk_gate_a: assert property (
    s_r.st == standby_pkg::ST_SETTLE && !sif.done |=> !cpu_clk_en_out)
    else $error("clock ungated before settle done");
  stop_entry_a: assert property (
    s_r.st == standby_pkg::ST_RUN && !halt_req_in && s_r.start
    && s_r.sel == standby_pkg::SEL_STOP |=> osc_stop_out ##1 !s_r.start || wr_commit)
    else $error("stop not entered");
  bus_ready_a: assert property (
    acc_first |=> pready ##1 !pready)
    else $error("bus answer not one cycle");

  halt_cycle_c: cover property (s_r.st == standby_pkg::ST_HALT ##1 cpu_clk_en_out);
  idle_cycle_c: cover property (s_r.st == standby_pkg::ST_IDLE ##1 cpu_clk_en_out);
  stop_wake_c: cover property (
    s_r.st == standby_pkg::ST_STOP ##[1:100] s_r.st == standby_pkg::ST_SETTLE);
endmodule : standby_mode_control

// >>> tb/cpu_irq_model.sv
// Far-side model: CPU halt pulses, interrupt sources and oscillator start-up
module cpu_irq_model #(
  parameter int START = 20
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic osc_stop_in,
  input wire logic halt_cmd_in,
  input wire logic [2:0] src_cmd_in,
  output logic halt_req_out,
  output logic [2:0] src_out,
  output logic osc_running_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int osc_cnt;
  int guard;
  assign osc_running_out = (osc_cnt == START);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_cnt <= 0;
      guard <= 0;
      halt_req_out <= 1'b0;
      src_out <= 3'h0;
    end else begin
      osc_cnt <= osc_stop_in ? 0 : (osc_cnt < START ? osc_cnt + 1 : osc_cnt);
      src_out <= src_cmd_in;
      halt_req_out <= halt_cmd_in && guard == 0;
      guard <= (halt_cmd_in && guard == 0) ? 5 : (guard > 0 ? guard - 1 : 0);
    end
  end
endmodule : cpu_irq_model

// >>> tb/standby_mode_control_bench.sv
// Self-checking bench of the standby mode controller
module standby_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BL = 2;
  localparam int START = 20;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic halt_cmd = 1'b0;
  logic [2:0] src_cmd = 3'h0;
  logic halt_req;
  logic [2:0] src;
  logic osc_run;
  logic clk_en;
  logic osc_stop;
  logic [5:0] state;
  int fails = 0;
  int n_compared = 0;
  int seed = 32'h68fb;
  int mreg [4] = '{0, 0, 6, 0};
  int n;
  int s;
  int idle_cyc = 0;
  logic [31:0] rd;
  logic err;
  standby_mode_control #(.BASE_LOG2(BL)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_req_in(halt_req),
    .irq_pending_in(src[2]), .nmi_a_in(src[0]), .nmi_b_in(src[1]),
    .osc_running_in(osc_run), .cpu_clk_en_out(clk_en), .osc_stop_out(osc_stop),
    .state_out(state));
  cpu_irq_model #(.START(START)) partner_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .osc_stop_in(osc_stop), .halt_cmd_in(halt_cmd), .src_cmd_in(src_cmd),
    .halt_req_out(halt_req), .src_out(src), .osc_running_out(osc_run));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(negedge clk_in) idle_cyc += (state === standby_pkg::ST_IDLE);
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_span(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      fails++;
      $display("MISMATCH %0t %s took %0d cycles", $time, what, got);
    end
  endtask : cmp_span
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int c;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    c = 0;
    // Woken at the edge, so pready and data are the values sampled there
    do begin
      @(posedge clk_in);
      c++;
    end while (pready !== 1'b1 && c < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t bus answer timed out", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Writes also update the register model; the start bit clears itself
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    mreg[a >> 2] = d & (a == standby_pkg::CTRL_OFF ? 7 : (a == standby_pkg::MODE_OFF ? 3 : 255));
    cmp_val(err, 1'b0, "write error");
  endtask : wr
  task automatic rdc(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    cmp_val(rd, mreg[a >> 2], "register read");
  endtask : rdc
  task automatic wait_st(input logic [5:0] t);
    n = 0;
    while (state !== t && n < 5000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    cmp_val(state, t, "state");
  endtask : wait_st
  // Whole run is under six hundred cycles; this allows over thirty times that
  initial begin
    #200000;
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out();
  end
  initial begin
    @(posedge clk_in);
    #1;
    cmp_val(state, standby_pkg::ST_OSC_WAIT, "reset state");
    cmp_val(clk_en, 1'b0, "reset clock gate");
    cmp_val({osc_stop, pready, pslverr}, 3'h0, "reset outputs");
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    wait_st(standby_pkg::ST_RUN);
    cmp_span(n, START + 256, START + 262, "reset settle");
    cmp_val(clk_en, 1'b1, "clock after settle");
    rdc(standby_pkg::SETTLE_OFF);
    apb(1'b0, standby_pkg::STAT_OFF, 32'h0);
    cmp_val(rd, standby_pkg::ST_RUN, "status read");
    for (int i = 0; i < 4; i++) begin
      wr(standby_pkg::MODE_OFF, i);
      wr(standby_pkg::CTRL_OFF, $random(seed) & 7);
      repeat (4) @(posedge clk_in);
      cmp_val(state, standby_pkg::ST_RUN, "select without start");
      rdc(standby_pkg::MODE_OFF);
      rdc(standby_pkg::CTRL_OFF);
      if (i % 2 == 1) begin
        wr(standby_pkg::CTRL_OFF, 8);
        repeat (4) @(posedge clk_in);
        cmp_val(state, standby_pkg::ST_RUN, "unsupported select");
        rdc(standby_pkg::CTRL_OFF);
      end
    end
    apb(1'b0, 12'h010, 32'h0);
    cmp_val({rd[30:0], err}, 32'h1, "unmapped access");
    s = ($random(seed) & 32'h7FFF) % 3;
    wr(standby_pkg::SETTLE_OFF, s);
    rdc(standby_pkg::SETTLE_OFF);
    wr(standby_pkg::CTRL_OFF, 4);
    wr(standby_pkg::MODE_OFF, 2);
    wr(standby_pkg::CTRL_OFF, 12);
    wait_st(standby_pkg::ST_STOP);
    cmp_val({osc_stop, clk_en}, 2'h2, "stop outputs");
    src_cmd <= 3'h4;
    repeat (10) @(posedge clk_in);
    #1;
    cmp_val(state, standby_pkg::ST_STOP, "masked wake");
    src_cmd <= 3'h1;
    wait_st(standby_pkg::ST_OSC_WAIT);
    wait_st(standby_pkg::ST_RUN);
    cmp_span(n, START + (1 << (BL + s)), START + (1 << (BL + s)) + 6, "stop settle");
    wr(standby_pkg::CTRL_OFF, 7);
    for (int k = 0; k < 2; k++) begin
      src_cmd <= k ? 3'h4 : 3'h0;
      repeat (8) @(posedge clk_in);
      halt_cmd <= 1'b1;
      @(posedge clk_in);
      halt_cmd <= 1'b0;
      wait_st(standby_pkg::ST_HALT);
      repeat (k ? 1 : 10) @(posedge clk_in);
      #1;
      cmp_val(state, k ? standby_pkg::ST_RUN : standby_pkg::ST_HALT, "halt exit");
      src_cmd <= 3'h2;
      wait_st(standby_pkg::ST_RUN);
      cmp_span(n, 0, 3, "halt release");
    end
    wr(standby_pkg::CTRL_OFF, 0);
    wr(standby_pkg::MODE_OFF, 0);
    idle_cyc = 0;
    wr(standby_pkg::CTRL_OFF, 8);
    repeat (5) @(posedge clk_in);
    cmp_span(idle_cyc, 1, 2, "idle with pending");
    cmp_val(state, standby_pkg::ST_RUN, "idle release");
    src_cmd <= 3'h7;
    wr(standby_pkg::CTRL_OFF, 7);
    wr(standby_pkg::CTRL_OFF, 15);
    repeat (20) @(posedge clk_in);
    #1;
    cmp_val(state, standby_pkg::ST_IDLE, "masked idle");
    wr(standby_pkg::CTRL_OFF, 0);
    wait_st(standby_pkg::ST_RUN);
    cmp_span(n, 0, 4, "unmasked idle release");
    close_out();
  end
endmodule : standby_mode_control_bench
